// file: ccag_pkg.sv
// Operation
// [RQ1] Input-value bit reads the current level on multifunction pin one.
// [RQ2] Output-value bit sets the level driven on pin one; resets to 0.
// [RQ3] Input bit meaningful in mode 1000; output bit drives pin in mode 1001.
// [RQ4] Two reserved registers read zero; host never writes them.
// [RQ5] Core clock source register upper seven bits read zero; host leaves them alone.
// [RQ6] Core clock from PLL divided output on 0, divider output on 1; resets 0.
// [RQ7] Divider input source: 00 master clock, 10 bit clock; 01/11 unused; resets 00.
// [RQ8] PLL input source: 00 master clock, 10 bit clock; 01/11 reserved; resets 00.
// [RQ9] PLL N field: 0000 is 16, 0001 is 17, others own value; resets 0010.
// [RQ10] Attack select 0 uses older AGC register; 1 uses new register; resets 0.
// [RQ11] Baseline attack codes 00..11 give 7, 8, 10, 11 ms; resets 00.
// [RQ12] Multiplier field scales baseline by two to the code; resets 000.
// [RQ13] Host writes only zeros to the two low reserved attack bits.
// [RQ14] Pin level is synchronised through flip-flops before it is read.
// [RQ15] Effective attack time is baseline times factor, presented only when selected.
`default_nettype none

package ccag_pkg;

	localparam int ADDR_W   = 8;
	localparam int REG_W    = 8;
	localparam int ATK_MS_W = 11;
	localparam int PLL_N_W  = 5;

	localparam logic [7:0] PIN_CTRL_OFS = 8'h62;
	localparam logic [7:0] RSVD_A_OFS   = 8'h63;
	localparam logic [7:0] RSVD_B_OFS   = 8'h64;
	localparam logic [7:0] CORE_SEL_OFS = 8'h65;
	localparam logic [7:0] CLKGEN_OFS   = 8'h66;
	localparam logic [7:0] ATTACK_OFS   = 8'h67;

	localparam int PIN_MODE_MSB = 7;
	localparam int PIN_MODE_LSB = 4;
	localparam int PIN_IN_BIT   = 1;
	localparam int PIN_OUT_BIT  = 0;
	localparam int CORE_SEL_BIT = 0;
	localparam int DIV_SRC_MSB  = 7;
	localparam int DIV_SRC_LSB  = 6;
	localparam int PLL_SRC_MSB  = 5;
	localparam int PLL_SRC_LSB  = 4;
	localparam int PLL_N_MSB    = 3;
	localparam int PLL_N_LSB    = 0;
	localparam int ATK_SEL_BIT  = 7;
	localparam int ATK_BASE_MSB = 6;
	localparam int ATK_BASE_LSB = 5;
	localparam int ATK_MULT_MSB = 4;
	localparam int ATK_MULT_LSB = 2;
	localparam int SRC_BCLK_BIT = 1;

	localparam logic [7:0] PIN_CTRL_RST = 8'h00;
	localparam logic [7:0] RSVD_VALUE   = 8'h00;
	localparam logic [0:0] CORE_SEL_RST = 1'h0;
	localparam logic [7:0] CLKGEN_RST   = 8'h02;
	localparam logic [7:0] ATTACK_RST   = 8'h00;

	localparam logic [3:0] PIN_MODE_GP_IN  = 4'h8;
	localparam logic [3:0] PIN_MODE_GP_OUT = 4'h9;

	localparam logic [10:0] ATK_BASE_MS_0 = 11'h007;
	localparam logic [10:0] ATK_BASE_MS_1 = 11'h008;
	localparam logic [10:0] ATK_BASE_MS_2 = 11'h00a;
	localparam logic [10:0] ATK_BASE_MS_3 = 11'h00b;
	localparam logic [4:0]  PLL_N_CODE0   = 5'h10;
	localparam logic [4:0]  PLL_N_CODE1   = 5'h11;

	// PLL N decode
	function automatic logic [4:0] pll_n_decode(input logic [3:0] code);
		case (code)
			4'h0:    return PLL_N_CODE0; // RQ9
			4'h1:    return PLL_N_CODE1; // RQ9
			default: return {1'b0, code}; // RQ9
		endcase
	endfunction : pll_n_decode

	// Baseline attack time in ms
	function automatic logic [10:0] attack_base_ms(input logic [1:0] code);
		case (code)
			2'h0:    return ATK_BASE_MS_0; // RQ11
			2'h1:    return ATK_BASE_MS_1; // RQ11
			2'h2:    return ATK_BASE_MS_2; // RQ11
			default: return ATK_BASE_MS_3; // RQ11
		endcase
	endfunction : attack_base_ms

	// Baseline scaled by two to the multiplier code
	function automatic logic [10:0] attack_scale(input logic [1:0] base, input logic [2:0] mult);
		logic [10:0] b;
		b = attack_base_ms(base);
		return b << mult; // RQ12
	endfunction : attack_scale

endpackage : ccag_pkg

`default_nettype wire

// file: ccag_attack_if.sv
`timescale 1ns/100ps
`default_nettype none

interface ccag_attack_if;
	logic        sel;
	logic [1:0]  base;
	logic [2:0]  mult;
	logic [10:0] time_ms;
	logic        from_new;

	modport cfg (output sel, output base, output mult, input time_ms, input from_new);
	modport calc (input sel, input base, input mult, output time_ms, output from_new);
endinterface : ccag_attack_if

`default_nettype wire

// file: ccag_attack_calc.sv
`timescale 1ns/100ps
`default_nettype none

module ccag_attack_calc (
	input  wire logic   clk_sys,
	input  wire logic   rst_n,
	ccag_attack_if.calc atk
);
	import ccag_pkg::*;

	// Effective attack time, zero while the older register is in charge
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			atk.time_ms  <= '0;
			atk.from_new <= 1'b0;
		end else begin
			atk.from_new <= atk.sel; // RQ10
			atk.time_ms  <= atk.sel ? attack_scale(atk.base, atk.mult) : '0; // RQ15
		end
	end

endmodule : ccag_attack_calc

`default_nettype wire

// file: ccag_regs.sv
`timescale 1ns/100ps
`default_nettype none

module ccag_regs (
	input  wire logic                       clk_sys,
	input  wire logic                       resetn,
	input  wire logic [ccag_pkg::ADDR_W-1:0] reg_addr,
	input  wire logic                       reg_wr,
	input  wire logic                       reg_rd,
	input  wire logic [ccag_pkg::REG_W-1:0]  reg_wdata,
	output logic      [ccag_pkg::REG_W-1:0]  reg_rdata,
	output logic                            reg_rvalid,
	input  wire logic                       multifunction_pin_one_i,
	output logic                            multifunction_pin_one_o,
	output logic                            multifunction_pin_one_oe_n,
	input  wire logic                       mclk_pin,
	input  wire logic                       bclk_pin,
	input  wire logic                       pll_divided_output,
	input  wire logic                       divider_path_output,
	output logic                            core_clock_input,
	output logic                            divider_path_input,
	output logic                            pll_reference_input,
	output logic      [ccag_pkg::PLL_N_W-1:0] pll_n_value,
	output logic                            agc_attack_from_new,
	output logic      [ccag_pkg::ATK_MS_W-1:0] agc_attack_ms
);
	import ccag_pkg::*;

	logic       rst_meta_reg;
	logic       rst_n;
	logic       pin_sync_a_reg;
	logic       pin_sync_b_reg;
	logic       pin_sync_c_reg;
	logic       pin_in_reg;
	logic [7:0] pin_ctrl_reg;
	logic       core_sel_reg;
	logic [7:0] clkgen_reg;
	logic [7:0] attack_reg;
	logic [7:0] rdata_next;
	logic [3:0] pin_mode;

	ccag_attack_if atk_if ();

	// Reset release through two flip-flops
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			rst_meta_reg <= 1'b0;
			rst_n        <= 1'b0;
		end else begin
			rst_meta_reg <= 1'b1;
			rst_n        <= rst_meta_reg;
		end
	end

	// Pin level synchroniser; change taken once the last two stages agree
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			pin_sync_a_reg <= 1'b0;
			pin_sync_b_reg <= 1'b0;
			pin_sync_c_reg <= 1'b0;
		end else begin
			pin_sync_a_reg <= multifunction_pin_one_i; // RQ14
			pin_sync_b_reg <= pin_sync_a_reg; // RQ14
			pin_sync_c_reg <= pin_sync_b_reg; // RQ14
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			pin_in_reg <= 1'b0;
		end else if (pin_sync_b_reg == pin_sync_c_reg) begin
			pin_in_reg <= pin_sync_c_reg; // RQ1
		end
	end

	// Pin control register; all eight bits stored, the input bit is replaced on read
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			pin_ctrl_reg <= PIN_CTRL_RST;
		end else if (reg_wr && reg_addr == PIN_CTRL_OFS) begin
			pin_ctrl_reg <= reg_wdata; // RQ2
		end
	end

	// Core clock source select; upper bits not stored
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			core_sel_reg <= CORE_SEL_RST; // RQ6
		end else if (reg_wr && reg_addr == CORE_SEL_OFS) begin
			core_sel_reg <= reg_wdata[CORE_SEL_BIT]; // RQ5
		end
	end

	// Clock generation control
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			clkgen_reg <= CLKGEN_RST; // RQ9
		end else if (reg_wr && reg_addr == CLKGEN_OFS) begin
			clkgen_reg <= reg_wdata;
		end
	end

	// Left AGC attack time
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			attack_reg <= ATTACK_RST;
		end else if (reg_wr && reg_addr == ATTACK_OFS) begin
			attack_reg <= reg_wdata; // RQ13
		end
	end

	// Read data mux; reserved and unmapped locations read zero
	always_comb begin
		rdata_next = RSVD_VALUE;
		case (reg_addr)
			PIN_CTRL_OFS: begin
				rdata_next              = pin_ctrl_reg;
				rdata_next[PIN_IN_BIT]  = pin_in_reg; // RQ1
			end
			RSVD_A_OFS:   rdata_next = RSVD_VALUE; // RQ4
			RSVD_B_OFS:   rdata_next = RSVD_VALUE; // RQ4
			CORE_SEL_OFS: rdata_next = {7'h00, core_sel_reg}; // RQ5
			CLKGEN_OFS:   rdata_next = clkgen_reg;
			ATTACK_OFS:   rdata_next = attack_reg;
			default:      rdata_next = RSVD_VALUE;
		endcase
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			reg_rdata  <= '0;
			reg_rvalid <= 1'b0;
		end else begin
			reg_rvalid <= reg_rd;
			if (reg_rd) begin
				reg_rdata <= rdata_next;
			end
		end
	end

	// Pin drive in general-purpose output mode only
	assign pin_mode                   = pin_ctrl_reg[PIN_MODE_MSB:PIN_MODE_LSB];
	assign multifunction_pin_one_o    = pin_ctrl_reg[PIN_OUT_BIT]; // RQ2
	assign multifunction_pin_one_oe_n = (pin_mode != PIN_MODE_GP_OUT); // RQ3

	// Clock source muxes
	assign core_clock_input    = core_sel_reg ? divider_path_output : pll_divided_output; // RQ6
	assign divider_path_input  = clkgen_reg[DIV_SRC_MSB - 1 + SRC_BCLK_BIT] ? bclk_pin : mclk_pin; // RQ7
	assign pll_reference_input = clkgen_reg[PLL_SRC_LSB + SRC_BCLK_BIT] ? bclk_pin : mclk_pin; // RQ8

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			pll_n_value <= pll_n_decode(CLKGEN_RST[PLL_N_MSB:PLL_N_LSB]);
		end else begin
			pll_n_value <= pll_n_decode(clkgen_reg[PLL_N_MSB:PLL_N_LSB]); // RQ9
		end
	end

	// Attack time calculation
	assign atk_if.sel  = attack_reg[ATK_SEL_BIT]; // RQ10
	assign atk_if.base = attack_reg[ATK_BASE_MSB:ATK_BASE_LSB]; // RQ11
	assign atk_if.mult = attack_reg[ATK_MULT_MSB:ATK_MULT_LSB]; // RQ12

	ccag_attack_calc u_attack_calc (
		.clk_sys (clk_sys),
		.rst_n   (rst_n),
		.atk     (atk_if.calc)
	);

	assign agc_attack_from_new = atk_if.from_new;
	assign agc_attack_ms       = atk_if.time_ms;

	// Checks
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!rst_n);

	property p_pin_in;
		(pin_sync_b_reg == pin_sync_c_reg) |=> (pin_in_reg == $past(pin_sync_c_reg));
	endproperty
	a_pin_in: assert property (p_pin_in) else $error("pin input value not tracked"); // RQ1

	property p_pin_in_read;
		(reg_rd && reg_addr == PIN_CTRL_OFS) |=> reg_rvalid && reg_rdata[PIN_IN_BIT] == $past(pin_in_reg);
	endproperty
	a_pin_in_read: assert property (p_pin_in_read) else $error("pin input bit read wrong"); // RQ1

	property p_pin_out;
		(reg_wr && reg_addr == PIN_CTRL_OFS && reg_wdata[7:4] == PIN_MODE_GP_OUT)
			|=> !multifunction_pin_one_oe_n && multifunction_pin_one_o == $past(reg_wdata[0]);
	endproperty
	a_pin_out: assert property (p_pin_out) else $error("pin not driven with output value"); // RQ2

	property p_pin_release;
		(reg_wr && reg_addr == PIN_CTRL_OFS && reg_wdata[7:4] != PIN_MODE_GP_OUT)
			|=> multifunction_pin_one_oe_n;
	endproperty
	a_pin_release: assert property (p_pin_release) else $error("pin driven outside output mode"); // RQ3

	property p_rsvd_zero;
		(reg_rd && (reg_addr == RSVD_A_OFS || reg_addr == RSVD_B_OFS)) |=> reg_rvalid && reg_rdata == 8'h00;
	endproperty
	a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved register not zero"); // RQ4

	property p_core_upper;
		(reg_rd && reg_addr == CORE_SEL_OFS) |=> reg_rdata[7:1] == 7'h00 && reg_rdata[0] == $past(core_sel_reg);
	endproperty
	a_core_upper: assert property (p_core_upper) else $error("core select readback wrong"); // RQ5

	property p_core_mux;
		(reg_wr && reg_addr == CORE_SEL_OFS)
			|=> core_clock_input == ($past(reg_wdata[0]) ? divider_path_output : pll_divided_output);
	endproperty
	a_core_mux: assert property (p_core_mux) else $error("core clock source wrong"); // RQ6

	property p_src_mux;
		(clkgen_reg[7:6] == 2'h2 |-> divider_path_input == bclk_pin) and
		(clkgen_reg[5:4] == 2'h0 |-> pll_reference_input == mclk_pin);
	endproperty
	a_src_mux: assert property (p_src_mux) else $error("clock source select wrong"); // RQ7

	property p_pll_n;
		(reg_wr && reg_addr == CLKGEN_OFS && reg_wdata[3:0] == 4'h0) |=> ##1 pll_n_value == 5'h10;
	endproperty
	a_pll_n: assert property (p_pll_n) else $error("N code zero not decoded as 16"); // RQ9

	property p_attack_new;
		($stable(attack_reg) && attack_reg[ATK_SEL_BIT])
			|-> agc_attack_from_new && agc_attack_ms == attack_scale(attack_reg[6:5], attack_reg[4:2]);
	endproperty
	a_attack_new: assert property (p_attack_new) else $error("attack time wrong"); // RQ15

	property p_attack_old;
		(reg_wr && reg_addr == ATTACK_OFS && !reg_wdata[7]) |=> ##1 !agc_attack_from_new && agc_attack_ms == 11'h000;
	endproperty
	a_attack_old: assert property (p_attack_old) else $error("attack shown while deselected"); // RQ10

	property p_attack_max;
		(reg_wr && reg_addr == ATTACK_OFS && reg_wdata[7:2] == 6'h3f) |=> ##1 agc_attack_ms == 11'h580;
	endproperty
	a_attack_max: assert property (p_attack_max) else $error("longest attack not 1408 ms"); // RQ12

	property p_pin_sync;
		$changed(pin_in_reg)
			|-> pin_in_reg == $past(multifunction_pin_one_i, 4)
			&& pin_in_reg == $past(multifunction_pin_one_i, 3);
	endproperty
	a_pin_sync: assert property (p_pin_sync) else $error("pin level taken unsettled"); // RQ14

	property p_pin_ctrl_hold;
		!(reg_wr && reg_addr == PIN_CTRL_OFS) |=> $stable(pin_ctrl_reg);
	endproperty
	a_pin_ctrl_hold: assert property (p_pin_ctrl_hold) else $error("pin control changed"); // RQ2

	property p_core_hold;
		!(reg_wr && reg_addr == CORE_SEL_OFS) |=> $stable(core_sel_reg);
	endproperty
	a_core_hold: assert property (p_core_hold) else $error("core select changed"); // RQ6

	property p_clkgen_hold;
		!(reg_wr && reg_addr == CLKGEN_OFS) |=> $stable(clkgen_reg);
	endproperty
	a_clkgen_hold: assert property (p_clkgen_hold) else $error("clock control changed"); // RQ7

	property p_attack_hold;
		!(reg_wr && reg_addr == ATTACK_OFS) |=> $stable(attack_reg);
	endproperty
	a_attack_hold: assert property (p_attack_hold) else $error("attack control changed"); // RQ10

	property p_rd_answer;
		reg_rd |=> reg_rvalid;
	endproperty
	a_rd_answer: assert property (p_rd_answer) else $error("read not answered"); // RQ4

	property p_rd_quiet;
		!reg_rd |=> !reg_rvalid && $stable(reg_rdata);
	endproperty
	a_rd_quiet: assert property (p_rd_quiet) else $error("read answer without read"); // RQ4

	property p_pll_n_one;
		(reg_wr && reg_addr == CLKGEN_OFS && reg_wdata[3:0] == 4'h1) |=> ##1 pll_n_value == 5'h11;
	endproperty
	a_pll_n_one: assert property (p_pll_n_one) else $error("N code one not 17"); // RQ9

	property p_pll_n_plain;
		(reg_wr && reg_addr == CLKGEN_OFS && reg_wdata[3:1] != 3'h0)
			|=> ##1 pll_n_value == {1'b0, $past(reg_wdata[3:0], 2)};
	endproperty
	a_pll_n_plain: assert property (p_pll_n_plain) else $error("N code not own value"); // RQ9

	property p_src_mux_b;
		(clkgen_reg[7:6] == 2'h0 |-> divider_path_input == mclk_pin) and
		(clkgen_reg[5:4] == 2'h2 |-> pll_reference_input == bclk_pin);
	endproperty
	a_src_mux_b: assert property (p_src_mux_b) else $error("clock source select wrong"); // RQ8

	property p_attack_sel_new;
		(reg_wr && reg_addr == ATTACK_OFS && reg_wdata[7]) |=> ##1 agc_attack_from_new;
	endproperty
	a_attack_sel_new: assert property (p_attack_sel_new) else $error("new attack not taken"); // RQ10

	c_pin_out: cover property (reg_wr && reg_addr == PIN_CTRL_OFS && reg_wdata[7:4] == PIN_MODE_GP_OUT);
	c_pin_in:  cover property (reg_rd && reg_addr == PIN_CTRL_OFS && pin_in_reg);
	c_pll_n:   cover property (reg_wr && reg_addr == CLKGEN_OFS ##2 pll_n_value == 5'h11);
	c_attack:  cover property (agc_attack_from_new && agc_attack_ms > 11'h00b);
	c_pin_chg: cover property ($changed(pin_in_reg));

endmodule : ccag_regs

`default_nettype wire

// file: ccag_host.sv
`timescale 1ns/100ps
`default_nettype none

module ccag_host (
	input  wire logic                        clk_sys,
	output logic      [ccag_pkg::ADDR_W-1:0] reg_addr,
	output logic                             reg_wr,
	output logic                             reg_rd,
	output logic      [ccag_pkg::REG_W-1:0]  reg_wdata
);
	import ccag_pkg::*;

	initial begin
		reg_addr = 8'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_wdata = 8'h00;
	end

	// Byte write; released lines show the inverse of the last value
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic [7:0] v;
		v = d;
		if (a == RSVD_A_OFS || a == RSVD_B_OFS) return;
		if (a == CORE_SEL_OFS) v[7:1] = 7'h00;
		if (a == CLKGEN_OFS) v = v & 8'haf;
		if (a == ATTACK_OFS) v[1:0] = 2'h0;
		@(posedge clk_sys);
		#1;
		reg_addr = a;
		reg_wdata = v;
		reg_wr = 1'b1;
		@(posedge clk_sys);
		#1;
		reg_wr = 1'b0;
		reg_wdata = ~v;
		reg_addr = ~a;
	endtask : wr

	task automatic rd(input logic [7:0] a);
		@(posedge clk_sys);
		#1;
		reg_addr = a;
		reg_rd = 1'b1;
		@(posedge clk_sys);
		#1;
		reg_rd = 1'b0;
		reg_addr = ~a;
	endtask : rd
endmodule : ccag_host

`default_nettype wire

// file: codec_clock_and_agc_attack_regs_test.sv
`timescale 1ns/100ps
`default_nettype none

module codec_clock_and_agc_attack_regs_test;
	import ccag_pkg::*;
	logic        clk_sys, resetn, pin_ext, pin_wire, mclk, bclk, pll_div, div_out;
	logic [7:0]  reg_addr, reg_wdata, reg_rdata;
	logic        reg_wr, reg_rd, reg_rvalid, pin_o, pin_oe_n, core_clk, div_in, pll_ref, atk_new;
	logic [4:0]  pll_n;
	logic [10:0] atk_ms;
	logic [1:0]  src;
	logic [7:0]  exp_q[$];
	logic [10:0] base_ms[4] = '{11'h007, 11'h008, 11'h00a, 11'h00b};
	int          failures, checks_done;

	assign pin_wire = (pin_oe_n === 1'b0) ? pin_o : pin_ext;

	ccag_host host (.clk_sys(clk_sys), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_wdata(reg_wdata));

	ccag_regs dut (.clk_sys(clk_sys), .resetn(resetn), .reg_addr(reg_addr), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
		.multifunction_pin_one_i(pin_wire), .multifunction_pin_one_o(pin_o),
		.multifunction_pin_one_oe_n(pin_oe_n), .mclk_pin(mclk), .bclk_pin(bclk),
		.pll_divided_output(pll_div), .divider_path_output(div_out),
		.core_clock_input(core_clk), .divider_path_input(div_in),
		.pll_reference_input(pll_ref), .pll_n_value(pll_n),
		.agc_attack_from_new(atk_new), .agc_attack_ms(atk_ms));

	task automatic cmp(input logic [10:0] got, input logic [10:0] exp);
		checks_done++;
		if (got !== exp) begin
			failures++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : cmp

	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		exp_q.push_back(e);
		host.rd(a);
	endtask : rd

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		host.wr(a, d);
		repeat (2) @(posedge clk_sys);
		#1;
	endtask : wr

	// New random levels on every clock source
	task automatic clocks;
		{mclk, bclk, pll_div, div_out} = 4'($urandom());
		#1;
	endtask : clocks

	task automatic test_done;
		$display("checks %0d failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : test_done

	// Read answers are matched against the oldest note, mid-cycle while the answer stands
	always @(negedge clk_sys) begin
		if (reg_rvalid === 1'b1) begin
			if (exp_q.size() == 0) begin
				failures++;
				$display("mismatch at %0t: unexpected read answer", $time);
			end else begin
				cmp({3'h0, reg_rdata}, {3'h0, exp_q.pop_front()});
			end
		end
	end

	initial begin
		clk_sys = 1'b0;
		forever #2 clk_sys = ~clk_sys;
	end

	initial begin
		repeat (20000) @(posedge clk_sys);
		failures++;
		$display("mismatch at %0t: run did not finish", $time);
		test_done();
	end

	initial begin
		resetn = 1'b0;
		pin_ext = 1'b0;
		{mclk, bclk, pll_div, div_out} = 4'h0;
		failures = 0;
		checks_done = 0;
		void'($urandom(16));
		repeat (4) @(posedge clk_sys);
		#1;
		resetn = 1'b1;
		repeat (3) @(posedge clk_sys);
		#1;
		cmp(11'(pll_n), 11'h002);
		cmp(11'(pin_oe_n), 11'h001);
		cmp(atk_ms, 11'h000);
		rd(PIN_CTRL_OFS, 8'h00);
		rd(RSVD_A_OFS, 8'h00);
		rd(RSVD_B_OFS, 8'h00);
		rd(CORE_SEL_OFS, 8'h00);
		rd(CLKGEN_OFS, 8'h02);
		rd(ATTACK_OFS, 8'h00);
		wr(8'h70, 8'hff);
		rd(8'h70, 8'h00);
		for (int n = 0; n < 16; n++) begin
			src = 2'($urandom());
			wr(CLKGEN_OFS, {src[1], 1'b0, src[0], 1'b0, 4'(n)});
			clocks();
			cmp(11'(pll_n), (n < 2) ? 11'(16 + n) : 11'(n));
			cmp(11'(div_in), 11'(src[1] ? bclk : mclk));
			cmp(11'(pll_ref), 11'(src[0] ? bclk : mclk));
		end
		rd(CLKGEN_OFS, {src[1], 1'b0, src[0], 1'b0, 4'hf});
		for (int s = 0; s < 2; s++) begin
			wr(CORE_SEL_OFS, 8'(s));
			clocks();
			cmp(11'(core_clk), 11'(s ? div_out : pll_div));
			rd(CORE_SEL_OFS, 8'(s));
		end
		for (int k = 0; k < 32; k++) begin
			wr(ATTACK_OFS, {1'b1, 5'(k), 2'h0});
			cmp(atk_ms, base_ms[k[4:3]] << k[2:0]);
			cmp(11'(atk_new), 11'h001);
		end
		wr(ATTACK_OFS, 8'h74);
		cmp(atk_ms, 11'h000);
		cmp(11'(atk_new), 11'h000);
		rd(ATTACK_OFS, 8'h74);
		wr(PIN_CTRL_OFS, 8'h91);
		cmp(11'(pin_oe_n), 11'h000);
		cmp(11'(pin_o), 11'h001);
		wr(PIN_CTRL_OFS, 8'h90);
		cmp(11'(pin_o), 11'h000);
		wr(PIN_CTRL_OFS, 8'h81);
		cmp(11'(pin_oe_n), 11'h001);
		pin_ext = 1'b1;
		repeat (6) @(posedge clk_sys);
		#1;
		rd(PIN_CTRL_OFS, 8'h83);
		pin_ext = 1'b0;
		rd(PIN_CTRL_OFS, 8'h83);
		repeat (6) @(posedge clk_sys);
		#1;
		rd(PIN_CTRL_OFS, 8'h81);
		repeat (4) @(posedge clk_sys);
		cmp(11'(exp_q.size()), 11'h000);
		test_done();
	end
endmodule : codec_clock_and_agc_attack_regs_test

`default_nettype wire
